// >>> pkg/qfe_pkg.sv
`default_nettype none
package qfe_pkg;
    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_EDGES    = 8'h04;
    localparam logic [7:0]  ADDR_CAP      = 8'h08;
    localparam logic [7:0]  ADDR_MONITOR  = 8'h0C;
    localparam logic [7:0]  ADDR_POSITION = 8'h10;
    localparam int          CTRL_LEAD_BIT = 0;
    localparam int          CTRL_ZFMT_BIT = 1;

    // ************************************************
    // counts and reset values
    // ************************************************
    localparam logic [22:0] SENSOR_CNT    = 23'h280000;  // 2 621 440 per rev
    localparam logic [22:0] EDGES_MAX     = 23'h500000;  // 5 242 880
    localparam logic [22:0] EDGES_RST     = 23'h014000;  // 81 920
    localparam logic [13:0] CAP_MAX       = 14'h2710;    // 10.000 rev/s in milli
    localparam logic [13:0] CAP_MIN       = 14'h0001;    // 0.001 rev/s
    localparam logic [31:0] MILLI_PER_ONE = 32'h000003E8;
    localparam logic [4:0]  DIV_STEPS     = 5'h1F;

    // ************************************************
    // timing
    // ************************************************
    localparam longint      CLK_HZ        = 100_000_000;
    localparam longint      EDGE_RATE_MAX = 3_125_000;   // edges per second
    localparam longint      ZPULSE_NS     = 1000;
    localparam int          EDGE_GAP_CYC  = int'((CLK_HZ + EDGE_RATE_MAX - 1) / EDGE_RATE_MAX);
    localparam int          ZPULSE_CYC    = int'((ZPULSE_NS * CLK_HZ) / 1_000_000_000);
    localparam logic [31:0] CAP_NUM       = 32'(EDGE_RATE_MAX * 1000);

    typedef enum logic {
        QFE_DIV_IDLE = 1'b0,
        QFE_DIV_RUN  = 1'b1
    } qfe_div_e;
endpackage
`default_nettype wire

// >>> hw/qfe_top.sv
// Operation
// - edge total per rev selectable, default 81920
// - setting zero suppresses all A/B edges
// - each phase carries half of the edges
// - eighty index pulses per revolution
// - lead select picks A or B leading
// - index format normal or MSB
// - edge rate never above 3 125 000/s
// - speed cap recomputed on resolution change
// - internal move speed clipped to cap
// - fractional residue accumulated from home origin
// - index rising edge repeatable both directions in normal format
// - A, B and Z edges not aligned
// - signed edge-total monitor, starts at zero
// - sensor gives 2 621 440 counts per rev
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module qfe_top
    import qfe_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    output var  logic [31:0] rdData,
    input  wire logic        sensStep,
    input  wire logic        sensCw,
    input  wire logic        homeSet,
    input  wire logic [13:0] cmdSpeed,
    output var  logic [13:0] limitedSpeed,
    output var  logic        phase_a_out,
    output var  logic        phase_a_out_inv,
    output var  logic        phase_b_out,
    output var  logic        phase_b_out_inv,
    output var  logic        index_out,
    output var  logic        index_out_inv
);
    typedef struct packed {
        logic [21:0]        pos;
        logic               moved;
        logic [22:0]        acc;
        logic signed [3:0]  owe;
        logic [5:0]         gap;
        logic [1:0]         quad;
        logic [7:0]         zTmr;
        logic               lead;
        logic               zFmt;
        logic [22:0]        fr;
        logic [13:0]        cap;
        qfe_div_e           div;
        logic [31:0]        dNum;
        logic [23:0]        dRem;
        logic [31:0]        dQuo;
        logic [4:0]         dCnt;
        logic [31:0]        mon;
        logic [31:0]        rd;
        logic [13:0]        spd;
        logic               a;
        logic               ai;
        logic               b;
        logic               bi;
        logic               z;
        logic               zi;
    } qfe_state_s;

    qfe_state_s s_reg;
    qfe_state_s s_next;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        logic [23:0]       sum;
        logic signed [2:0] delta;
        logic signed [5:0] oweSum;
        logic              emit;
        logic              emitUp;
        logic [1:0]        gray;
        logic [23:0]       remShift;
        logic [13:0]       capNew;
        sum      = 24'h000000;
        delta    = 3'sd0;
        oweSum   = 6'sd0;
        emit     = 1'b0;
        emitUp   = 1'b0;
        gray     = 2'h0;
        remShift = 24'h000000;
        capNew   = CAP_MAX;
        s_next   = s_reg;
        s_next.moved = 1'b0;

        // sensor position and residue; home resets the origin of the scaling
        if (homeSet) begin
            s_next.pos   = 22'h000000;
            s_next.acc   = 23'h000000;
            s_next.moved = 1'b1;
        end else if (sensStep) begin
            s_next.moved = 1'b1;
            if (sensCw) begin
                s_next.pos = (s_reg.pos == SENSOR_CNT[21:0] - 22'h1) ? 22'h000000
                                                                      : s_reg.pos + 22'h1;
                sum = {1'b0, s_reg.acc} + {1'b0, s_reg.fr};
                if (sum >= {SENSOR_CNT, 1'b0}) begin
                    s_next.acc = 23'(sum - {SENSOR_CNT, 1'b0});
                    delta      = 3'sd2;
                end else if (sum >= {1'b0, SENSOR_CNT}) begin
                    s_next.acc = 23'(sum - {1'b0, SENSOR_CNT});
                    delta      = 3'sd1;
                end else begin
                    s_next.acc = sum[22:0];
                end
            end else begin
                s_next.pos = (s_reg.pos == 22'h000000) ? SENSOR_CNT[21:0] - 22'h1
                                                       : s_reg.pos - 22'h1;
                if (s_reg.acc >= s_reg.fr) begin
                    s_next.acc = s_reg.acc - s_reg.fr;
                end else if ({1'b0, s_reg.acc} + {1'b0, SENSOR_CNT} >= {1'b0, s_reg.fr}) begin
                    s_next.acc = 23'({1'b0, s_reg.acc} + {1'b0, SENSOR_CNT} - {1'b0, s_reg.fr});
                    delta      = -3'sd1;
                end else begin
                    s_next.acc = 23'({1'b0, s_reg.acc} + {SENSOR_CNT, 1'b0} - {1'b0, s_reg.fr});
                    delta      = -3'sd2;
                end
            end
        end

        // edge emitter: a fixed gap keeps the edge rate under the ceiling;
        // bursts faster than that are owed, and the debt saturates at seven
        if (s_reg.gap != 6'h00) begin
            s_next.gap = s_reg.gap - 6'h01;
        end else if (s_reg.owe != 4'sd0 && s_reg.fr != 23'h000000) begin
            emit       = 1'b1;
            emitUp     = (s_reg.owe > 4'sd0);
            s_next.gap = 6'(EDGE_GAP_CYC - 1);
        end
        oweSum = 6'(s_reg.owe) + 6'(delta) - (emit ? (emitUp ? 6'sd1 : -6'sd1) : 6'sd0);
        if (s_reg.fr == 23'h000000) begin
            s_next.owe = 4'sd0;
        end else if (oweSum > 6'sd7) begin
            s_next.owe = 4'sd7;
        end else if (oweSum < -6'sd7) begin
            s_next.owe = -4'sd7;
        end else begin
            s_next.owe = 4'(oweSum);
        end
        if (emit) begin
            s_next.quad = emitUp ? s_reg.quad + 2'h1 : s_reg.quad - 2'h1;
            s_next.mon  = emitUp ? s_reg.mon + 32'h1 : s_reg.mon - 32'h1;
        end
        gray       = s_next.quad ^ {1'b0, s_next.quad[1]};
        s_next.a   = s_reg.lead ? gray[1] : gray[0];
        s_next.b   = s_reg.lead ? gray[0] : gray[1];
        s_next.ai  = ~s_next.a;
        s_next.bi  = ~s_next.b;

        // index: pos[14:0] wraps 80 times per rev; in normal format the pulse is
        // launched only on reaching the mark, so its rising edge is the same
        // place both ways while its falling edge follows time, not position
        if (s_reg.zFmt) begin
            s_next.z    = s_reg.pos[14];
            s_next.zTmr = 8'h00;
        end else if (s_reg.moved && s_reg.pos[14:0] == 15'h0000) begin
            s_next.z    = 1'b1;
            s_next.zTmr = 8'(ZPULSE_CYC - 1);
        end else if (s_reg.zTmr != 8'h00) begin
            s_next.zTmr = s_reg.zTmr - 8'h01;
        end else begin
            s_next.z = 1'b0;
        end
        s_next.zi = ~s_next.z;

        // speed cap = edge ceiling / edges per rev, by a serial divider
        if (s_reg.div == QFE_DIV_RUN) begin
            remShift    = {s_reg.dRem[22:0], s_reg.dNum[31]};
            s_next.dNum = {s_reg.dNum[30:0], 1'b0};
            if (remShift >= {1'b0, s_reg.fr}) begin
                s_next.dRem = remShift - {1'b0, s_reg.fr};
                s_next.dQuo = {s_reg.dQuo[30:0], 1'b1};
            end else begin
                s_next.dRem = remShift;
                s_next.dQuo = {s_reg.dQuo[30:0], 1'b0};
            end
            s_next.dCnt = s_reg.dCnt + 5'h01;
            if (s_reg.dCnt == DIV_STEPS) begin
                s_next.div = QFE_DIV_IDLE;
                if (s_reg.fr == 23'h000000 || s_next.dQuo >= 32'(CAP_MAX)) begin
                    capNew = CAP_MAX;
                end else if (s_next.dQuo < 32'(CAP_MIN)) begin
                    capNew = CAP_MIN;
                end else begin
                    capNew = s_next.dQuo[13:0];
                end
                s_next.cap = capNew;
            end
        end

        // internal move speed never beyond the cap
        s_next.spd = (cmdSpeed > s_reg.cap) ? s_reg.cap : cmdSpeed;

        // register writes
        if (wrEn) begin
            case (addr)
                ADDR_CTRL: begin
                    s_next.lead = wrData[CTRL_LEAD_BIT];
                    s_next.zFmt = wrData[CTRL_ZFMT_BIT];
                end
                ADDR_EDGES: begin
                    // out-of-range values are dropped so the cap stays valid
                    if (wrData <= 32'(EDGES_MAX)) begin
                        s_next.fr   = wrData[22:0];
                        s_next.owe  = 4'sd0;
                        s_next.acc  = 23'h000000;
                        s_next.div  = QFE_DIV_RUN;
                        s_next.dNum = CAP_NUM;
                        s_next.dRem = 24'h000000;
                        s_next.dQuo = 32'h00000000;
                        s_next.dCnt = 5'h00;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads, data valid in the following cycle only
        s_next.rd = 32'h00000000;
        if (rdEn) begin
            case (addr)
                ADDR_CTRL:     s_next.rd = {30'h0, s_reg.zFmt, s_reg.lead};
                ADDR_EDGES:    s_next.rd = {9'h000, s_reg.fr};
                ADDR_CAP:      s_next.rd = {18'h00000, s_reg.cap};
                ADDR_MONITOR:  s_next.rd = s_reg.mon;
                ADDR_POSITION: s_next.rd = {10'h000, s_reg.pos};
                default:       s_next.rd = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_reg      <= '0;
            s_reg.fr   <= EDGES_RST;
            s_reg.cap  <= CAP_MAX;
            s_reg.div  <= QFE_DIV_IDLE;
            s_reg.ai   <= 1'b1;
            s_reg.bi   <= 1'b1;
            s_reg.zi   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdData          = s_reg.rd;
    assign limitedSpeed    = s_reg.spd;
    assign phase_a_out     = s_reg.a;
    assign phase_a_out_inv = s_reg.ai;
    assign phase_b_out     = s_reg.b;
    assign phase_b_out_inv = s_reg.bi;
    assign index_out       = s_reg.z;
    assign index_out_inv   = s_reg.zi;

    // ************************************************
    // checks
    // ************************************************
    logic [5:0] sinceEdge;
    logic [1:0] prevAb;
    logic       abEdge;
    assign abEdge = ({phase_a_out, phase_b_out} != prevAb);
    always_ff @(posedge clock) begin
        prevAb <= {phase_a_out, phase_b_out};
        if (!rst_b) begin
            sinceEdge <= 6'h3F;
        end else if (abEdge) begin
            sinceEdge <= 6'h00;
        end else if (sinceEdge != 6'h3F) begin
            sinceEdge <= sinceEdge + 6'h01;
        end
    end
    property p_gap;
        @(posedge clock) disable iff (!rst_b) abEdge |-> sinceEdge >= 6'(EDGE_GAP_CYC - 1);
    endproperty
    a_gap: assert property (p_gap) else $error("feedback edges too close");
    property p_gray;
        @(posedge clock) disable iff (!rst_b)
        abEdge |-> (phase_a_out ^ $past(phase_a_out)) != (phase_b_out ^ $past(phase_b_out));
    endproperty
    a_gray: assert property (p_gray) else $error("both phases changed at once");
    property p_inv;
        @(posedge clock) disable iff (!rst_b)
        phase_a_out_inv == !phase_a_out && phase_b_out_inv == !phase_b_out
            && index_out_inv == !index_out;
    endproperty
    a_inv: assert property (p_inv) else $error("inverse output mismatch");
    property p_off;
        @(posedge clock) disable iff (!rst_b)
        (s_reg.fr == 23'h000000) ##1 (s_reg.fr == 23'h000000) |-> !abEdge;
    endproperty
    a_off: assert property (p_off) else $error("edge while feedback off");
    property p_mon;
        @(posedge clock) disable iff (!rst_b)
        abEdge |-> (s_reg.mon == $past(s_reg.mon) + 32'h1) || (s_reg.mon == $past(s_reg.mon) - 32'h1);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor missed an edge");
    property p_cap;
        @(posedge clock) disable iff (!rst_b) s_reg.cap >= CAP_MIN && s_reg.cap <= CAP_MAX;
    endproperty
    a_cap: assert property (p_cap) else $error("speed cap out of range");
    property p_capdone;
        @(posedge clock) disable iff (!rst_b)
        wrEn && addr == ADDR_EDGES && wrData == 32'(EDGES_MAX) ##1 !wrEn [*8]
            |-> ##[1:40] s_reg.div == QFE_DIV_IDLE && s_reg.cap == 14'h0254;
    endproperty
    a_capdone: assert property (p_capdone) else $error("cap not recomputed");
    property p_spd;
        @(posedge clock) disable iff (!rst_b) limitedSpeed <= $past(s_reg.cap);
    endproperty
    a_spd: assert property (p_spd) else $error("speed above cap");
    property p_zrise;
        @(posedge clock) disable iff (!rst_b)
        $rose(index_out) && !$past(s_reg.zFmt) |-> $past(s_reg.pos[14:0]) == 15'h0000;
    endproperty
    a_zrise: assert property (p_zrise) else $error("index rose off its mark");
    property p_res;
        @(posedge clock) disable iff (!rst_b) s_reg.acc < SENSOR_CNT;
    endproperty
    a_res: assert property (p_res) else $error("residue out of range");
endmodule
`default_nettype wire

// >>> hw/unused_placeholder_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> sim/qfe_counter_model.sv
`timescale 1ns/1ps
`default_nettype none
module qfe_counter_model
    import qfe_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic phaseA,
    input  wire logic phaseAInv,
    input  wire logic phaseB,
    input  wire logic phaseBInv,
    input  wire logic index,
    input  wire logic indexInv,
    input  wire logic leadB,
    output var  int   count,
    output var  int   zRises,
    output var  int   faults
);
    // ********************************************
    // master side: quadrature and index counting
    // ********************************************
    logic       prevA;
    logic       prevB;
    logic       prevZ;
    logic [1:0] qNow;
    logic [1:0] qOld;
    int         since;

    // swapping the lanes folds both lead settings onto one step table
    assign qNow = leadB ? {phaseA, phaseA ^ phaseB} : {phaseB, phaseA ^ phaseB};
    assign qOld = leadB ? {prevA, prevA ^ prevB} : {prevB, prevA ^ prevB};

    always @(posedge clock) begin
        if (!rst_b) begin
            count = 0;
            zRises = 0;
            faults = 0;
            since = 1000;
        end else begin
            since++;
            if ({phaseAInv, phaseBInv, indexInv} !== ~{phaseA, phaseB, index}) begin
                faults++;
            end
            if (qNow !== qOld) begin
                if (since < EDGE_GAP_CYC) begin
                    faults++;
                end
                since = 0;
                case (qNow - qOld)
                    2'h1: count++;
                    2'h3: count--;
                    default: faults++;
                endcase
            end
            // the falling edge moves with direction, so only rises are counted
            if (index && !prevZ) begin
                zRises++;
            end
        end
        prevA = phaseA;
        prevB = phaseB;
        prevZ = index;
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import qfe_pkg::*;
;
    logic        clock, rst_b, wrEn, rdEn, sensStep, sensCw, homeSet, leadB;
    logic [7:0]  addr;
    logic [31:0] wrData, rdData, got;
    logic [13:0] cmdSpeed, limitedSpeed;
    logic        pa, paInv, pb, pbInv, zOut, zInv;
    int          count, zRises, faults;
    int          errCount = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    int          expMon = 0;

    qfe_top dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .sensStep(sensStep), .sensCw(sensCw),
        .homeSet(homeSet), .cmdSpeed(cmdSpeed), .limitedSpeed(limitedSpeed),
        .phase_a_out(pa), .phase_a_out_inv(paInv), .phase_b_out(pb),
        .phase_b_out_inv(pbInv), .index_out(zOut), .index_out_inv(zInv)
    );
    qfe_counter_model peer (
        .clock(clock), .rst_b(rst_b), .phaseA(pa), .phaseAInv(paInv), .phaseB(pb),
        .phaseBInv(pbInv), .index(zOut), .indexInv(zInv), .leadB(leadB),
        .count(count), .zRises(zRises), .faults(faults)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // longest scenario is the index run of 32768 steps
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            errCount++;
            conclude();
        end
    end

    // ********************************************
    // bus and pin tasks
    // ********************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            errCount++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clock);
        wrEn <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clock);
        rdEn <= 1'b0;
        #1;
        chk(rdData, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic step(input logic cw, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            sensStep <= 1'b1;
            sensCw <= cw;
            repeat (gap - 1) begin
                @(posedge clock);
                sensStep <= 1'b0;
            end
        end
        @(posedge clock);
        sensStep <= 1'b0;
    endtask
    task automatic home();
        @(posedge clock);
        homeSet <= 1'b1;
        @(posedge clock);
        homeSet <= 1'b0;
    endtask
    task automatic monChk();
        rdChk(ADDR_MONITOR, 32'(expMon));
        chk(32'(count), 32'(expMon));
    endtask
    task automatic conclude();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ********************************************
    // scenarios
    // ********************************************
    task automatic t_regs();
        rdChk(ADDR_EDGES, 32'(EDGES_RST));
        rdChk(ADDR_CAP, 32'(CAP_MAX));
        rdChk(ADDR_MONITOR, 32'h0);
        rdChk(ADDR_CTRL, 32'h0);
        rdChk(8'h20, 32'h0);
        wr(ADDR_EDGES, 32'(EDGES_MAX) + 32'h1);
        idle(40);
        rdChk(ADDR_EDGES, 32'(EDGES_RST));
    endtask
    task automatic t_cap();
        wr(ADDR_EDGES, 32'(EDGES_MAX));
        idle(40);
        rdChk(ADDR_EDGES, 32'(EDGES_MAX));
        rdChk(ADDR_CAP, CAP_NUM / 32'(EDGES_MAX));
        @(posedge clock) cmdSpeed <= CAP_MAX;
        idle(3);
        chk(32'(limitedSpeed), CAP_NUM / 32'(EDGES_MAX));
        @(posedge clock) cmdSpeed <= 14'h0064;
        idle(3);
        chk(32'(limitedSpeed), 32'h00000064);
        // one edge above the point where the cap leaves its ceiling
        wr(ADDR_EDGES, 32'h0004C4B5);
        idle(40);
        rdChk(ADDR_CAP, CAP_NUM / 32'h0004C4B5);
    endtask
    task automatic t_quad(input logic lead);
        wr(ADDR_CTRL, {31'h0, lead});
        leadB <= lead;
        wr(ADDR_EDGES, 32'(SENSOR_CNT));
        rdChk(ADDR_CTRL, {31'h0, lead});
        step(1'b1, 8, 40);
        idle(60);
        expMon += 8;
        monChk();
        step(1'b0, 8, 40);
        idle(60);
        expMon -= 8;
        monChk();
        chk(32'(faults), 32'h0);
    endtask
    task automatic t_burst();
        step(1'b1, 6, 1);
        idle(300);
        expMon += 6;
        monChk();
        chk(32'(faults), 32'h0);
    endtask
    task automatic t_zero();
        wr(ADDR_EDGES, 32'h0);
        step(1'b1, 8, 40);
        idle(60);
        monChk();
        rdChk(ADDR_CAP, 32'(CAP_MAX));
    endtask
    task automatic t_residue();
        wr(ADDR_EDGES, 32'(SENSOR_CNT) >> 1);
        step(1'b1, 1, 40);
        home();
        step(1'b1, 1, 40);
        idle(60);
        monChk();
        step(1'b1, 1, 40);
        idle(60);
        expMon += 1;
        monChk();
    endtask
    task automatic t_index();
        wr(ADDR_EDGES, 32'h0);
        home();
        idle(150);
        got = 32'(zRises);
        step(1'b1, 32768, 1);
        idle(150);
        chk(32'(zRises) - got, 32'h1);
        rdChk(ADDR_POSITION, 32'h00008000);
        wr(ADDR_CTRL, 32'h3);
        idle(3);
        chk({30'h0, zOut, zInv}, 32'h1);
        step(1'b0, 1, 1);
        idle(3);
        chk({30'h0, zOut, zInv}, 32'h2);
    endtask

    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wrData = 32'h0;
        {wrEn, rdEn, sensStep, sensCw, homeSet, leadB} = 6'h00;
        cmdSpeed = 14'h0000;
        repeat (3) @(posedge clock);
        #1;
        chk({26'h0, pa, paInv, pb, pbInv, zOut, zInv}, 32'h15);
        @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_cap();
        t_quad(1'b0);
        t_burst();
        t_quad(1'b1);
        t_zero();
        t_residue();
        t_index();
        conclude();
    end
endmodule
`default_nettype wire
